// ==== core/sth_spi_slave.sv ====
/*
  spi slave transaction handler: link shifter on the spi clock,
  header decoder and register request port on mclk.
  assumes the host is the only spi master, that the register side
  answers a read one mclk cycle after the request, and that the
  spi mode pins are tied before reset is released.
*/
`timescale 1ns/100ps
`default_nettype none
module sth_spi_slave
  import sth_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wake,
  input wire logic gpio_pol,
  input wire logic gpio_pha,
  input wire logic otp_lock,
  input wire sth_mode_t otp_mode,
  input wire logic sclk,
  input wire logic host_select_low,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  output sth_mode_t spi_mode,
  output logic req_valid,
  output sth_req_t req,
  input wire logic [7:0] rd_data,
  output logic fast_valid,
  output logic [4:0] fast_code
);

  // fast command: write, short, tail bit set
  function automatic logic is_fast(input logic [7:0] b);
    return b[HDR_DIR] && !b[HDR_LONG] && b[HDR_TAIL];
  endfunction

  // index of the last mask octet from the two mode bits
  function automatic logic [1:0] mask_last(input logic [1:0] m);
    case (m)
      2'h1: mask_last = 2'h0;
      2'h2: mask_last = 2'h1;
      default: mask_last = 2'h3;
    endcase
  endfunction

  // pin synchronisers, change accepted when stages 2 and 3 agree
  logic [1:0] pin_raw;
  logic [1:0] pin_q;
  assign pin_raw = {gpio_pol, gpio_pha};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic [PIN_STAGES-1:0] sy;
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          sy <= '0;
          pin_q[gi] <= 1'b0;
        end else begin
          sy <= {sy[PIN_STAGES-2:0], pin_raw[gi]};
          if (sy[1] == sy[2]) begin
            pin_q[gi] <= sy[2];
          end
        end
      end
    end
  endgenerate

  // wait for the pin chains to fill after reset or wake
  logic [2:0] cap_cnt;
  logic cap_go;
  assign cap_go = (cap_cnt == 3'h1);
  always_ff @(posedge mclk) begin
    if (!nrst || wake) begin
      cap_cnt <= CAP_WAIT;
    end else if (cap_cnt != 3'h0) begin
      cap_cnt <= cap_cnt - 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      spi_mode <= '{pol: POL_RST, pha: PHA_RST};
    end else if (cap_go) begin
      spi_mode <= otp_lock ? otp_mode : sth_mode_t'(pin_q);
    end
  end

  // slave only: host owns sclk
  // sample edge is the rising edge of lk in every mode;
  // mode bits are static during frames, so the xor is glitch free
  logic lk;
  assign lk = sclk ^ spi_mode.pol ^ spi_mode.pha;

  // link side state, reset while select is high (dir_lk to one, the rest to zero except rd_hold, which is on mclk and keeps its value)
  logic [2:0] bit_cnt;
  logic [1:0] oct_cnt;
  logic [6:0] sh_in;
  logic [7:0] byte_lk;
  logic tgl_lk;
  logic dir_lk;
  logic long_lk;
  logic [7:0] sh_out;
  logic [7:0] rd_hold;
  logic rd_phase;

  // select high ends the frame on the link side
  always_ff @(posedge lk or posedge host_select_low) begin
    if (host_select_low) begin
      bit_cnt <= 3'h0;
      oct_cnt <= 2'h0;
      sh_in <= 7'h00;
      byte_lk <= 8'h00;
      tgl_lk <= 1'b0;
    end else begin
      sh_in <= {sh_in[5:0], mosi};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        byte_lk <= {sh_in, mosi};
        tgl_lk <= ~tgl_lk;
        if (oct_cnt != 2'h3) begin
          oct_cnt <= oct_cnt + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge lk or posedge host_select_low) begin
    if (host_select_low) begin
      dir_lk <= 1'b1;
      long_lk <= 1'b0;
    end else if (oct_cnt == 2'h0) begin
      if (bit_cnt == 3'h0) begin
        dir_lk <= mosi;
      end
      if (bit_cnt == 3'h1) begin
        long_lk <= mosi;
      end
    end
  end

  // data octets of a read follow the one or two header octets
  assign rd_phase = !dir_lk && (oct_cnt > {1'b0, long_lk});

  // msb first shift out on the launch edge
  // rd_hold only moves in the idle gap the host leaves between octets,
  // so it is steady whenever the link side looks at it
  always_ff @(negedge lk or posedge host_select_low) begin
    if (host_select_low) begin
      sh_out <= 8'h00;
    end else if (bit_cnt == 3'h1 && rd_phase) begin
      sh_out <= {rd_hold[6:0], 1'b0};
    end else begin
      sh_out <= {sh_out[6:0], 1'b0};
    end
  end

  // output stays meaningless during writes, host ignores it
  // first bit of a read octet comes straight from rd_hold: in the
  // leading-edge modes the last launch edge falls half a link clock
  // after the octet, before the fetch can cross back from the core
  assign miso_o = (bit_cnt == 3'h0 && rd_phase) ? rd_hold[7] : sh_out[7];
  assign miso_oe = !host_select_low;

  // select synchroniser, agreement of stages 2 and 3
  logic [PIN_STAGES-1:0] sel_sy;
  logic sel_q;
  logic sel_prev;
  logic sel_fall;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sel_sy <= '1;
      sel_q <= 1'b1;
      sel_prev <= 1'b1;
    end else begin
      sel_sy <= {sel_sy[PIN_STAGES-2:0], host_select_low};
      if (sel_sy[1] == sel_sy[2]) begin
        sel_q <= sel_sy[2];
      end
      sel_prev <= sel_q;
    end
  end
  assign sel_fall = sel_prev && !sel_q;

  // byte toggle crossing; its chain is longer than the select
  // chain so that the end-of-frame clear is seen after select
  logic [TGL_STAGES-1:0] tgl_sy;
  logic tgl_seen;
  logic ev;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tgl_sy <= '0;
      tgl_seen <= 1'b0;
    end else begin
      tgl_sy <= {tgl_sy[TGL_STAGES-2:0], tgl_lk};
      tgl_seen <= tgl_sy[TGL_STAGES-1];
    end
  end
  assign ev = !sel_q && (tgl_sy[TGL_STAGES-1] != tgl_seen);

  // byte_lk is stable for a whole octet after its toggle
  logic [7:0] b;
  assign b = byte_lk;

  // transaction decoder and request issue
  sth_state_t st;
  logic wr;
  logic sub_hi;
  logic [4:0] file;
  logic [6:0] off;
  logic [1:0] idx;
  logic [1:0] last;
  logic [7:0] and_buf [AND_DEPTH];
  always_ff @(posedge mclk) begin
    req_valid <= 1'b0;
    fast_valid <= 1'b0;
    if (!nrst) begin
      st <= ST_HDR;
      wr <= 1'b0;
      sub_hi <= 1'b0;
      file <= 5'h00;
      off <= 7'h00;
      idx <= 2'h0;
      last <= 2'h0;
      req <= '0;
      fast_code <= 5'h00;
      and_buf <= '{default: 8'h00};
    end else if (sel_q || sel_fall) begin
      st <= ST_HDR;
      idx <= 2'h0;
    end else if (ev) begin
      case (st)
        ST_HDR: begin
          file <= b[HDR_FILE_HI:HDR_FILE_LO];
          wr <= b[HDR_DIR];
          sub_hi <= b[HDR_TAIL];
          if (b[HDR_LONG]) begin
            st <= ST_HDR2;
          end else if (is_fast(b)) begin
            fast_valid <= 1'b1;
            fast_code <= b[HDR_FILE_HI:HDR_FILE_LO];
            st <= ST_SKIP;
          // short header starts at offset zero
          end else if (b[HDR_DIR]) begin
            off <= 7'h00;
            st <= ST_WR;
          end else begin
            req_valid <= 1'b1;
            req <= '{write: 1'b0, masked: 1'b0,
                     file: b[HDR_FILE_HI:HDR_FILE_LO],
                     offset: 7'h00, data: 8'h00, mask: 8'h00};
            off <= 7'h01;
            st <= ST_RD;
          end
        end
        ST_HDR2: begin
          // seven bit offset across both octets
          off <= {sub_hi, b[SUB_HI:SUB_LO]};
          if (!wr) begin
            req_valid <= 1'b1;
            req <= '{write: 1'b0, masked: 1'b0, file: file,
                     offset: {sub_hi, b[SUB_HI:SUB_LO]},
                     data: 8'h00, mask: 8'h00};
            off <= {sub_hi, b[SUB_HI:SUB_LO]} + 7'h01;
            st <= ST_RD;
          // zero mode bits mean plain write
          end else if (b[MODE_HI:MODE_LO] == MODE_PLAIN) begin
            st <= ST_WR;
          end else begin
            last <= mask_last(b[MODE_HI:MODE_LO]);
            idx <= 2'h0;
            st <= ST_AND;
          end
        end
        ST_WR: begin
          req_valid <= 1'b1;
          req <= '{write: 1'b1, masked: 1'b0, file: file,
                   offset: off, data: b, mask: 8'h00};
          off <= off + 7'h01;
        end
        ST_RD: begin
          // incoming octet ignored, fetch the next one
          req_valid <= 1'b1;
          req <= '{write: 1'b0, masked: 1'b0, file: file,
                   offset: off, data: 8'h00, mask: 8'h00};
          off <= off + 7'h01;
        end
        ST_AND: begin
          and_buf[idx] <= b;
          idx <= (idx == last) ? 2'h0 : idx + 2'h1;
          if (idx == last) begin
            st <= ST_OR;
          end
        end
        ST_OR: begin
          // or mask pairs with the stored and octet
          req_valid <= 1'b1;
          req <= '{write: 1'b1, masked: 1'b1, file: file,
                   offset: off + {5'h00, idx}, data: b,
                   mask: and_buf[idx]};
          idx <= idx + 2'h1;
          if (idx == last) begin
            st <= ST_SKIP;
          end
        end
        default: begin
          // extra octets after a command or mask are dropped
          st <= ST_SKIP;
        end
      endcase
    end
  end

  // read answer lands one cycle after the request
  logic rd_pend;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_pend <= 1'b0;
      rd_hold <= 8'h00;
    end else begin
      rd_pend <= req_valid && !req.write;
      if (rd_pend) begin
        rd_hold <= rd_data;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_mode_cap;
    cap_go |=> spi_mode == $past(otp_lock ? otp_mode : sth_mode_t'(pin_q));
  endproperty
  a_mode_cap: assert property (p_mode_cap)
    else $error("spi mode not captured");

  property p_mode_hold;
    (cap_cnt == 3'h0) && !wake |=> $stable(spi_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("spi mode changed outside capture");

  property p_fast;
    (st == ST_HDR) && ev && !sel_fall && is_fast(b)
      |=> fast_valid && !req_valid && fast_code == $past(b[5:1]);
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast command not reported");

  property p_short_rd;
    (st == ST_HDR) && ev && !sel_fall && !b[HDR_DIR] && !b[HDR_LONG]
      |=> req_valid && !req.write && req.offset == 7'h00
          && req.file == $past(b[5:1]) ##1 st == ST_RD || sel_q;
  endproperty
  a_short_rd: assert property (p_short_rd)
    else $error("short read request wrong");

  property p_long_rd;
    (st == ST_HDR2) && ev && !sel_fall && !wr
      |=> req_valid && !req.write
          && req.offset == $past({sub_hi, b[7:2]});
  endproperty
  a_long_rd: assert property (p_long_rd)
    else $error("long read offset wrong");

  property p_wr_step;
    (st == ST_WR) && ev && !sel_fall
      |=> req_valid && req.write && req.offset == $past(off)
          && off == $past(off) + 7'h01 && req.data == $past(b);
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("write offset did not step");

  property p_rd_ignore;
    (st == ST_RD) && ev && !sel_fall
      |=> req_valid && !req.write ##2 rd_hold == $past(rd_data);
  endproperty
  a_rd_ignore: assert property (p_rd_ignore)
    else $error("read octet not ignored");

  property p_masked;
    (st == ST_OR) && ev && !sel_fall
      |=> req.masked && req.mask == $past(and_buf[idx]);
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked write pairing wrong");

  property p_start;
    sel_fall |=> st == ST_HDR && !req_valid;
  endproperty
  a_start: assert property (p_start)
    else $error("header decode not restarted");

  property p_end;
    sel_q [*2] |=> !req_valid && !fast_valid && st == ST_HDR;
  endproperty
  a_end: assert property (p_end)
    else $error("activity while deselected");

endmodule // sth_spi_slave
`default_nettype wire

// ==== core/sth_pkg.sv ====
/*
  shared constants and types for the spi transaction handler.
  assumes one core clock and one link clock taken from the spi pins.
*/
package sth_pkg;
  // header octet 0 fields, msb first on the wire
  localparam int HDR_DIR = 7;
  localparam int HDR_LONG = 6;
  localparam int HDR_FILE_HI = 5;
  localparam int HDR_FILE_LO = 1;
  localparam int HDR_TAIL = 0;
  // header octet 1 fields
  localparam int SUB_HI = 7;
  localparam int SUB_LO = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  // masks of up to four octets each
  localparam int AND_DEPTH = 4;
  // reset values of the captured spi mode
  localparam logic POL_RST = 1'b0;
  localparam logic PHA_RST = 1'b0;
  // core cycles before pins are trusted after reset or wake;
  // the pin chains need four edges after reset before they agree
  localparam logic [2:0] CAP_WAIT = 3'h6;
  // stages on the byte toggle: longer than the select chain
  localparam int TGL_STAGES = 5;
  localparam int PIN_STAGES = 3;

  typedef enum logic [2:0] {
    ST_HDR = 3'b000,
    ST_HDR2 = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b011,
    ST_AND = 3'b100,
    ST_OR = 3'b101,
    ST_SKIP = 3'b110
  } sth_state_t;

  typedef struct packed {
    logic pol;
    logic pha;
  } sth_mode_t;

  typedef struct packed {
    logic write;
    logic masked;
    logic [4:0] file;
    logic [6:0] offset;
    logic [7:0] data;
    logic [7:0] mask;
  } sth_req_t;
endpackage

// ==== verif/sth_host_model.sv ====
/*
  host spi master model: drives clock, select and data, samples miso.
  assumes the bench sets pol/pha to the mode the device should hold.
*/
`timescale 1ns/100ps
`default_nettype none
module sth_host_model (
  input wire logic pol,
  input wire logic pha,
  input wire logic miso,
  output logic sclk,
  output logic host_select_low,
  output logic mosi
);
  // idle: deselected, clock parked
  initial begin
    sclk = 1'b0;
    host_select_low = 1'b1;
    mosi = 1'b0;
  end

  task automatic frame_start();
    sclk = pol;
    #103;
    host_select_low = 1'b0;
    #200;
  endtask

  // msb first; clock stands still after each octet so read fetches can cross
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      if (!pha)
        mosi = tx[i];
      #80;
      sclk = ~pol;
      if (pha)
        mosi = tx[i];
      else
        rx[i] = miso;
      #80;
      sclk = pol;
      if (pha)
        rx[i] = miso;
    end
    #200;
  endtask

  // release ends the frame; data line flips so stale bits never look valid
  task automatic frame_end();
    host_select_low = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule // sth_host_model
`default_nettype wire

// ==== verif/test_spi_slave_transaction_handler.sv ====
/*
  self-checking bench for sth_spi_slave, one task per scenario.
  assumes sth_pkg and the host model sth_host_model on the link.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %0t %s", $time, m); end end
module test_spi_slave_transaction_handler
  import sth_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wake = 1'b0;
  logic gpio_pol = 1'b0;
  logic gpio_pha = 1'b0;
  logic otp_lock = 1'b0;
  sth_mode_t otp_mode = '0;
  logic m_pol = 1'b0;
  logic m_pha = 1'b0;
  logic sclk, host_select_low, mosi, miso_o, miso_oe, miso_w, req_valid, fast_valid;
  sth_mode_t spi_mode;
  sth_req_t req;
  logic [7:0] rd_data = 8'h00;
  logic [4:0] fast_code;
  logic [7:0] regs [32][128];
  sth_req_t wq [$];
  logic [4:0] fq [$];
  logic [7:0] tx [$];
  logic [7:0] rx [$];
  int comparisons = 0;
  int n_mismatch = 0;

  // unwritten register bytes read as zero, never unknown
  initial begin
    foreach (regs[f, o])
      regs[f][o] = 8'h00;
  end

  sth_spi_slave uut (
    .mclk(mclk), .nrst(nrst), .wake(wake), .gpio_pol(gpio_pol), .gpio_pha(gpio_pha),
    .otp_lock(otp_lock), .otp_mode(otp_mode), .sclk(sclk), .host_select_low(host_select_low),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .spi_mode(spi_mode), .req_valid(req_valid),
    .req(req), .rd_data(rd_data), .fast_valid(fast_valid), .fast_code(fast_code)
  );
  assign miso_w = miso_oe ? miso_o : 1'bz;
  sth_host_model host (
    .pol(m_pol), .pha(m_pha), .miso(miso_w), .sclk(sclk), .host_select_low(host_select_low),
    .mosi(mosi)
  );

  always #5 mclk = ~mclk;

  // register side: answers reads one cycle on, logs writes and commands
  always @(posedge mclk) begin
    if (req_valid && !req.write)
      rd_data <= regs[req.file][req.offset];
    if (req_valid && req.write)
      wq.push_back(req);
    if (fast_valid)
      fq.push_back(fast_code);
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic do_reset(input logic p, input logic h);
    @(negedge mclk);
    nrst = 1'b0;
    gpio_pol = p;
    gpio_pha = h;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    repeat (12) @(negedge mclk);
    m_pol = otp_lock ? otp_mode.pol : p;
    m_pha = otp_lock ? otp_mode.pha : h;
  endtask

  // one framed exchange of tx, plus a partial octet of tail bits
  task automatic frame(input int tail);
    logic [7:0] b;
    wq.delete();
    fq.delete();
    rx = {};
    host.frame_start();
    `CHK(miso_oe, 1'b1, "miso idle while selected")
    foreach (tx[i]) begin
      host.xfer(tx[i], 8, b);
      rx.push_back(b);
    end
    if (tail > 0)
      host.xfer(8'h55, tail, b);
    host.frame_end();
    repeat (30) @(negedge mclk);
    `CHK(miso_oe, 1'b0, "miso driven while deselected")
  endtask

  task automatic chk_wr(input int i, input logic [4:0] f, input logic [6:0] o, input logic [7:0] d);
    `CHK({wq[i].write, wq[i].masked, wq[i].file, wq[i].offset, wq[i].data}, {2'b10, f, o, d}, "write req")
  endtask

  // replies during writes are never looked at
  task automatic t_write_short();
    tx = {8'h86, 8'hA1, 8'h5E};
    frame(3);
    `CHK(wq.size(), 2, "short write count")
    chk_wr(0, 5'h03, 7'h00, 8'hA1);
    chk_wr(1, 5'h03, 7'h01, 8'h5E);
    fin("write_short");
  endtask

  task automatic t_read();
    regs[0][0] = 8'h12;
    regs[0][1] = 8'hA5;
    regs[0][2] = 8'h3C;
    tx = {8'h00, 8'hFF, 8'h86, 8'hFF};
    frame(0);
    `CHK(rx[1], 8'h12, "read octet 0")
    `CHK(rx[2], 8'hA5, "read octet 1")
    `CHK(rx[3], 8'h3C, "read octet 2")
    `CHK(wq.size(), 0, "read produced a write")
    fin("read");
  endtask

  // long write offsets step per octet and wrap from 7F back to 00
  task automatic t_long();
    tx = {8'hC4, 8'h70, 8'h39, 8'h45};
    frame(0);
    chk_wr(0, 5'h02, 7'h1C, 8'h39);
    chk_wr(1, 5'h02, 7'h1D, 8'h45);
    tx = {8'hC5, 8'hFC, 8'h66, 8'h99};
    frame(0);
    chk_wr(0, 5'h02, 7'h7F, 8'h66);
    chk_wr(1, 5'h02, 7'h00, 8'h99);
    fin("long");
  endtask

  task automatic t_fast();
    logic [4:0] code;
    logic [7:0] hdr;
    for (int c = 0; c < 2; c++) begin
      code = c ? 5'h1F : 5'h01;
      hdr = {2'b10, code, 1'b1};
      tx = {hdr, 8'h86, 8'h11};
      frame(0);
      `CHK(fq.size(), 1, "fast count")
      `CHK(fq[0], code, "fast code")
      `CHK(wq.size(), 0, "fast produced a write")
    end
    fin("fast");
  endtask

  // masks aimed at plain data, never at event bits
  task automatic t_masked();
    logic [7:0] hdr;
    int n;
    for (int m = 1; m < 4; m++) begin
      n = (m == 3) ? 4 : m;
      hdr = {6'h10, m[1:0]};
      tx = {8'hC8, hdr};
      for (int k = 0; k < n; k++)
        tx.push_back(8'hF0 ^ k[7:0]);
      for (int k = 0; k < n; k++)
        tx.push_back(k[7:0] + 8'h01);
      tx.push_back(8'h77);
      frame(0);
      `CHK(wq.size(), n, "masked count")
      for (int k = 0; k < n; k++) begin
        `CHK({wq[k].masked, wq[k].file, wq[k].offset, wq[k].mask, wq[k].data},
          {1'b1, 5'h04, 7'h10 + k[6:0], 8'hF0 ^ k[7:0], k[7:0] + 8'h01}, "masked req")
      end
    end
    fin("masked");
  endtask

  task automatic t_restart();
    tx = {};
    frame(5);
    tx = {8'h8A, 8'h3C};
    frame(0);
    `CHK(wq.size(), 1, "fresh header count")
    chk_wr(0, 5'h05, 7'h00, 8'h3C);
    fin("restart");
  endtask

  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1], m[0]);
      `CHK(spi_mode, {m[1], m[0]}, "strap mode")
      t_write_short();
      t_read();
    end
    @(negedge mclk);
    gpio_pol = 1'b1;
    gpio_pha = 1'b0;
    repeat (5) @(negedge mclk);
    wake = 1'b1;
    @(negedge mclk);
    wake = 1'b0;
    repeat (12) @(negedge mclk);
    `CHK(spi_mode, 2'b10, "wake mode")
    m_pol = 1'b1;
    m_pha = 1'b0;
    t_fast();
    otp_lock = 1'b1;
    otp_mode = 2'b01;
    do_reset(1'b1, 1'b1);
    `CHK(spi_mode, 2'b01, "otp mode")
    fin("mode");
  endtask

  // main sequence
  initial begin
    t_mode();
    t_long();
    t_masked();
    t_restart();
    summarize();
  end

  // watchdog: the run needs well under a third of this
  initial begin
    #900_000;
    n_mismatch++;
    $display("mismatch %0t watchdog expired", $time);
    summarize();
  end
endmodule // test_spi_slave_transaction_handler
`default_nettype wire
